// file: hdl/sync_tx_path_maint_clock.sv
// Transmit bit path controller with maintenance clock selection and loopback
//
// Behaviour
// - Controller uses protocol select, synced requests, ones counts, load strobe to steer path.
// - Bit counter enable drops while a stuffed zero is inserted.
// - Output selector picks shift bit, CRC MSB or controller space/mark.
// - Shift register advances only when qualifier set; off for control, CRC, stuff, load.
// - CRC advances only when qualifier set; off for control chars and stuffed zeros.
// - Buffer low eight bits load into shift register only on load-transfer.
// - High selected bit means mark, low means space.
// - Free-running 20 kHz reference runs always and feeds the maintenance divider.
// - Maintenance divider is a 4-bit up counter giving ref/2, /4, /8, /16.
// - 5 kHz output is system test clock and, gated by the step bit, the system test internal clock.
// - External maintenance drives 10 kHz divider output off the device.
// - Mode bits select modem, 5 kHz, 10 kHz or single-step clock.
// - Equal mode bits hold divider in load at zero.
// - 5 kHz divider output readable as monitor bit in system test.
// - Internal clock follows 5 kHz output when low select and step bit set and high select clear; in internal maintenance it is the step bit.
// - Clear low select bit in external maintenance suppresses internal clock.
// - Status bit is transmit output OR maintenance data, only in internal maintenance.
// - Maintenance data as loop source inhibits transmitter and clears output flop.
// - Looped data clocks into receiver by the software-stepped maintenance clock.
// - Synced control buffer updates only at last bit once opening flag is sent.
// - Outside flags insert a zero after five consecutive ones.
// - Bit-oriented framing applies when protocol select is clear.
// - Undefined selector inputs output a mark only.
`timescale 1ns/10ps
module sync_tx_path_maint_clock #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   modem_tx_clock,
  input  wire logic                   maint_select_low,
  input  wire logic                   maint_select_high,
  input  wire logic                   maint_step_clock,
  input  wire logic                   maint_input_data,
  input  wire logic                   byte_protocol_select,
  input  wire logic                   abort_request,
  input  wire logic                   flag_request,
  input  wire logic                   crc_request,
  input  wire logic                   start_of_message,
  input  wire logic                   late_load_skip,
  input  wire logic                   tx_active,
  input  wire logic                   crc_msb,
  input  wire logic [7:0]             data_in,
  input  wire logic                   data_in_valid,
  output logic                        data_in_ready,
  output logic                        line_bit_value,
  output logic                        tx_output_flop,
  output logic                        crc_clock_enable,
  output logic                        bit_strobe,
  output logic                        external_clock_out,
  output logic                        internal_maint_clock,
  output logic                        system_test_clock_monitor,
  output logic                        maint_tx_data_out,
  output logic                        rx_serial_data,
  output logic                        rx_shift_strobe,
  output txpath_pkg::path_sel_t       path_sel,
  output txpath_pkg::sync_ctl_t       sync_ctl
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [2:0]                 mclk_s;
    logic [2:0]                 step_s;
    logic [15:0]                ref_cnt;
    logic                       ref_clk;
    logic [txpath_pkg::DIV_W-1:0] div;
    logic [7:0]                 shift;
    logic [2:0]                 character_bit_counter;
    logic [2:0]                 consecutive_ones_counter;
    logic                       flag_sent;
    logic                       loading;
    logic                       tx_out;
    txpath_pkg::sync_ctl_t      sctl;
    logic                       crc_en;
    logic                       bstrobe;
    logic                       rx_strobe;
  } st_t;

  st_t                     st_q;
  st_t                     st_d;
  txpath_pkg::maint_mode_t mode;
  logic                    tx_clk;
  logic                    tx_edge;
  logic                    ref_tick;
  logic                    div_run;
  logic                    div_st;
  logic                    div_ext;
  logic                    last_bit;
  logic                    stuff;
  logic                    in_flag;
  logic [2:0]              flag_idx;
  logic                    sel_bit;
  logic                    shift_qual;
  logic                    buf_load;
  logic                    inhibit;
  logic [7:0]              fifo_data;
  logic                    fifo_valid;

  assign mode = txpath_pkg::maint_mode_t'({maint_select_high, maint_select_low});

  tx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (data_in),
    .in_valid  (data_in_valid),
    .in_ready  (data_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (buf_load)
  );

  // ==========================================================================
  // Maintenance clocks
  assign ref_tick = (st_q.ref_cnt == 16'(txpath_pkg::REF_HALF_TICKS - 1));
  assign div_run  = maint_select_high ^ maint_select_low;
  assign div_st   = st_q.div[txpath_pkg::DIV_ST_BIT];
  assign div_ext  = st_q.div[txpath_pkg::DIV_EXT_BIT];

  // Low select gates both paths, so external mode has no internal clock
  assign internal_maint_clock = maint_select_low && st_q.step_s[1] && (div_st || !div_run);
  assign external_clock_out   = maint_select_high && !maint_select_low && div_ext;
  assign system_test_clock_monitor = div_st;

  always_comb
  begin
    case (mode)
      txpath_pkg::MODE_USER:      tx_clk = st_q.mclk_s[1];
      txpath_pkg::MODE_SYS_TEST:  tx_clk = internal_maint_clock;
      txpath_pkg::MODE_EXT_MAINT: tx_clk = div_ext;
      txpath_pkg::MODE_INT_MAINT: tx_clk = st_q.step_s[1];
      default:                    tx_clk = 1'b0;
    endcase
  end

  // Rising edge of selected clock; user clock edge from synced copy only
  assign tx_edge = tx_clk && !(mode == txpath_pkg::MODE_USER ? st_q.mclk_s[2] :
                               mode == txpath_pkg::MODE_INT_MAINT ? st_q.step_s[2] : st_q.bstrobe);

  // ==========================================================================
  // Path control
  assign inhibit  = maint_input_data;
  assign in_flag  = st_q.sctl.synced_flag_request || st_q.sctl.synced_abort_request;
  assign stuff    = !byte_protocol_select && !in_flag &&
                    (st_q.consecutive_ones_counter == 3'(txpath_pkg::ONES_STUFF));
  assign last_bit = (st_q.character_bit_counter == 3'(txpath_pkg::CHAR_BITS - 1));
  assign flag_idx = st_q.character_bit_counter;

  always_comb
  begin
    path_sel = '0;
    if (stuff)
    begin
      path_sel.force_space_bit = 1'b1;
    end
    else if (in_flag)
    begin
      path_sel.force_space_bit = !txpath_pkg::FLAG_CHAR[flag_idx];
      path_sel.bit_counter_enable = 1'b1;
    end
    else if (st_q.sctl.synced_crc_request)
    begin
      path_sel.select_crc_bit     = 1'b1;
      path_sel.bit_counter_enable = 1'b1;
    end
    else
    begin
      path_sel.select_shift_bit   = 1'b1;
      path_sel.bit_counter_enable = 1'b1;
    end
  end

  always_comb
  begin
    // Mark unless exactly one source is picked
    unique case ({path_sel.force_space_bit, path_sel.select_crc_bit, path_sel.select_shift_bit})
      3'b100:  sel_bit = 1'b0;
      3'b010:  sel_bit = crc_msb;
      3'b001:  sel_bit = st_q.shift[7];
      default: sel_bit = 1'b1;
    endcase
  end

  assign line_bit_value = sel_bit;
  assign buf_load   = tx_edge && last_bit && path_sel.bit_counter_enable &&
                      fifo_valid && !late_load_skip && !inhibit && tx_active;
  assign shift_qual = path_sel.select_shift_bit && !buf_load;

  always_comb
  begin
    st_d           = st_q;
    st_d.mclk_s    = {st_q.mclk_s[1:0], modem_tx_clock};
    st_d.step_s    = {st_q.step_s[1:0], maint_step_clock};
    st_d.bstrobe   = tx_clk;
    st_d.crc_en    = 1'b0;
    st_d.rx_strobe = 1'b0;
    st_d.ref_cnt   = ref_tick ? '0 : st_q.ref_cnt + 16'h0001;
    // Load is level-held, it does not wait for a reference edge
    if (!div_run)
    begin
      st_d.div = '0;
    end
    else if (ref_tick && !st_q.ref_clk)
    begin
      st_d.div = st_q.div + 4'h1;
    end
    if (ref_tick)
    begin
      st_d.ref_clk = !st_q.ref_clk;
    end
    if (inhibit || !tx_active)
    begin
      st_d.tx_out = 1'b0;
      st_d.consecutive_ones_counter = '0;
      st_d.character_bit_counter = '0;
      st_d.flag_sent = 1'b0;
      st_d.sctl = {abort_request, flag_request, crc_request, start_of_message};
    end
    else if (tx_edge)
    begin
      st_d.tx_out = sel_bit;
      st_d.crc_en = !in_flag && !stuff && path_sel.select_shift_bit;
      st_d.consecutive_ones_counter = sel_bit ?
        (st_q.consecutive_ones_counter == 3'(txpath_pkg::ONES_FLAG) ?
         st_q.consecutive_ones_counter : st_q.consecutive_ones_counter + 3'h1) : '0;
      if (path_sel.bit_counter_enable)
      begin
        st_d.character_bit_counter = st_q.character_bit_counter + 3'h1;
      end
      if (shift_qual)
      begin
        st_d.shift = {st_q.shift[6:0], 1'b0};
      end
      if (buf_load)
      begin
        st_d.shift = fifo_data;
      end
      if (path_sel.bit_counter_enable && last_bit)
      begin
        st_d.flag_sent = 1'b1;
      end
      // Before the opening flag ends, follow requests every bit
      if (!st_q.flag_sent || (path_sel.bit_counter_enable && last_bit))
      begin
        st_d.sctl = {abort_request, flag_request, crc_request, start_of_message};
      end
    end
    st_d.rx_strobe = tx_edge && (mode == txpath_pkg::MODE_INT_MAINT);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs and loopback
  assign tx_output_flop    = st_q.tx_out;
  assign crc_clock_enable  = st_q.crc_en;
  assign bit_strobe        = tx_edge;
  assign sync_ctl          = st_q.sctl;
  assign rx_serial_data    = st_q.tx_out || maint_input_data;
  assign rx_shift_strobe   = st_q.rx_strobe;
  assign maint_tx_data_out = (mode == txpath_pkg::MODE_INT_MAINT) &&
                             (st_q.tx_out || maint_input_data);

  // ==========================================================================
  // Checks
  property p_div_hold;
    @(posedge clk) disable iff (!rstn) !div_run |=> st_q.div == '0;
  endproperty
  a_div_hold : assert property (p_div_hold) else $error("divider not held");

  property p_status;
    @(posedge clk) disable iff (!rstn) (mode != txpath_pkg::MODE_INT_MAINT) |-> !maint_tx_data_out;
  endproperty
  a_status : assert property (p_status) else $error("status bit outside mode");

  property p_inhibit;
    @(posedge clk) disable iff (!rstn) inhibit |=> !tx_output_flop;
  endproperty
  a_inhibit : assert property (p_inhibit) else $error("output flop not cleared");

  property p_stuff;
    @(posedge clk) disable iff (!rstn) stuff |-> !path_sel.bit_counter_enable && !line_bit_value;
  endproperty
  a_stuff : assert property (p_stuff) else $error("stuffing wrong");

  property p_ext;
    @(posedge clk) disable iff (!rstn) (mode == txpath_pkg::MODE_EXT_MAINT) |-> !internal_maint_clock;
  endproperty
  a_ext : assert property (p_ext) else $error("internal clock in external mode");

  property p_load;
    @(posedge clk) disable iff (!rstn) buf_load |=> st_q.shift == $past(fifo_data);
  endproperty
  a_load : assert property (p_load) else $error("shift load wrong");

  property p_mark;
    @(posedge clk) disable iff (!rstn)
      !(path_sel.force_space_bit || path_sel.select_crc_bit || path_sel.select_shift_bit) |-> line_bit_value;
  endproperty
  a_mark : assert property (p_mark) else $error("undefined select not mark");

  property p_qual;
    @(posedge clk) disable iff (!rstn) (in_flag || buf_load) |-> !shift_qual;
  endproperty
  a_qual : assert property (p_qual) else $error("shift qualifier active");

endmodule : sync_tx_path_maint_clock

// file: pkg/txpath_pkg.sv
// Package: constants, modes and carrier structs for the transmit bit path
package txpath_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned REF_HZ         = 20_000;
  localparam int unsigned REF_HALF_TICKS = CLK_HZ / (2 * REF_HZ);
  localparam int unsigned DIV_W          = 4;
  localparam int unsigned CHAR_BITS      = 8;
  localparam int unsigned ONES_STUFF     = 5;
  localparam int unsigned ONES_FLAG      = 6;
  localparam int unsigned CRC_MSB        = 15;
  localparam int unsigned DIV_ST_BIT     = 1;
  localparam int unsigned DIV_EXT_BIT    = 0;
  localparam logic [7:0]  FLAG_CHAR      = 8'h7E;

  typedef enum logic [1:0] {
    MODE_USER,
    MODE_SYS_TEST,
    MODE_EXT_MAINT,
    MODE_INT_MAINT
  } maint_mode_t;

  // Synced control requests: follow the inputs while idle or until the first character ends, then update only at character boundaries
  typedef struct packed {
    logic synced_abort_request;
    logic synced_flag_request;
    logic synced_crc_request;
    logic synced_start_of_message;
  } sync_ctl_t;

  // Path selects produced by the controller
  typedef struct packed {
    logic force_space_bit;
    logic select_crc_bit;
    logic select_shift_bit;
    logic bit_counter_enable;
  } path_sel_t;

endpackage : txpath_pkg

// file: hdl/tx_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module tx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_st_t;

  fifo_st_t         st_q;
  fifo_st_t         st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_q.rd];

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st_q.wr] <= in_data;
    end
  end

  a_fifo_bound : assert property (@(posedge clk) disable iff (!rstn) st_q.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count out of range");
endmodule : tx_fifo

// file: dv/modem_model.sv
// Modem model: supplies the transmit bit clock and samples the sent bits
`timescale 1ns/10ps
module modem_model #(
  parameter int HALF = 8
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   run,
  input  wire logic   tx_bit,
  output logic        modem_tx_clock,
  output logic [15:0] bits_seen
);
  int cnt;

  // ==========================================================
  // Bit clock
  // Stands still at its current level while stalled, as a modem pausing a frame
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt            <= 0;
      modem_tx_clock <= 1'b0;
      bits_seen      <= 16'h0000;
    end
    else if (run)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
      begin
        modem_tx_clock <= !modem_tx_clock;
        if (!modem_tx_clock)
          bits_seen <= {bits_seen[14:0], tx_bit};
      end
    end
  end
endmodule : modem_model

// file: dv/sync_tx_path_maint_clock_tb.sv
// Testbench for the transmit bit path with maintenance clocks
`timescale 1ns/10ps
module sync_tx_path_maint_clock_tb;
  logic clk, rstn, mtc, sel_lo, sel_hi, step, mdata, proto, abrt, flg, crc, som, skip, act, crc_msb, run;
  logic [7:0] data_in;
  logic dv, rdy, lbv, txf, crc_en, strb, ext_clk, icl, mon, mout, rxd, rxs;
  txpath_pkg::path_sel_t psel;
  txpath_pkg::sync_ctl_t sctl;
  int fails, samples_checked;
  logic [15:0] seen;
  logic six_ones, flag_seen;

  sync_tx_path_maint_clock #(.FIFO_DEPTH(8)) i_dut (.clk(clk), .rstn(rstn), .modem_tx_clock(mtc),
    .maint_select_low(sel_lo), .maint_select_high(sel_hi), .maint_step_clock(step), .maint_input_data(mdata),
    .byte_protocol_select(proto), .abort_request(abrt), .flag_request(flg), .crc_request(crc),
    .start_of_message(som), .late_load_skip(skip), .tx_active(act), .crc_msb(crc_msb), .data_in(data_in),
    .data_in_valid(dv), .data_in_ready(rdy), .line_bit_value(lbv), .tx_output_flop(txf),
    .crc_clock_enable(crc_en), .bit_strobe(strb), .external_clock_out(ext_clk), .internal_maint_clock(icl),
    .system_test_clock_monitor(mon), .maint_tx_data_out(mout), .rx_serial_data(rxd), .rx_shift_strobe(rxs),
    .path_sel(psel), .sync_ctl(sctl));
  modem_model i_modem (.clk(clk), .rstn(rstn), .run(run), .tx_bit(txf), .modem_tx_clock(mtc), .bits_seen(seen));

  always #5 clk = !clk;
  always @(posedge clk) crc_msb <= !crc_msb;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic set_mode(input logic hi, input logic lo, input logic ss);
    @(posedge clk);
    sel_hi <= hi;
    sel_lo <= lo;
    step   <= ss;
    repeat (6) @(posedge clk);
  endtask : set_mode

  // Rising-edge spacing of ext clock (w=0) or monitor (w=1)
  task automatic measure(input int w, input int exp);
    int n, moves;
    logic prev, cur;
    moves = 0;
    n     = 0;
    prev  = 1'b1;
    cur   = 1'b1;
    while (!(cur && !prev) && n < 3 * exp)
    begin
      @(negedge clk);
      prev = cur;
      cur  = w ? mon : ext_clk;
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      if (w)
        check(icl, mon);
      else
        moves = moves + (icl ? 1 : 0);
      prev = cur;
      cur  = w ? mon : ext_clk;
      n++;
    end
    while (!(cur && !prev) && n < 3 * exp);
    check(n, exp);
    if (!w)
      check(moves, 0);
  endtask : measure

  task automatic fill(input int exp);
    int n;
    logic r;
    n = 0;
    @(posedge clk);
    data_in <= 8'hFF;
    dv      <= 1'b1;
    do
    begin
      @(negedge clk);
      r = rdy;
      @(posedge clk);
      n = n + (r ? 1 : 0);
    end
    while (r && n < 20);
    dv <= 1'b0;
    check(n, exp);
  endtask : fill

  // Bit stream checks while the modem clocks the path
  task automatic stream(input int cycles, output int strobes, output int stuffs);
    logic pend, pl, pe;
    pend    = 1'b0;
    strobes = 0;
    stuffs  = 0;
    repeat (cycles)
    begin
      @(negedge clk);
      if (pend)
      begin
        check(txf, pl);
        if (!pe)
          check(crc_en, 1'b0);
      end
      pend = strb;
      pl   = lbv;
      pe   = psel.bit_counter_enable;
      six_ones  = six_ones | (seen[5:0] == 6'h3F);
      flag_seen = flag_seen | (seen[7:0] == 8'h7E);
      if (strb)
      begin
        strobes++;
        if (psel.force_space_bit)
          check(lbv, 1'b0);
        if (psel.select_crc_bit)
          check(lbv, crc_msb);
        if (!pe && psel.force_space_bit)
          stuffs++;
      end
    end
  endtask : stream

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    @(negedge clk);
    check({txf, crc_en, ext_clk, mon, rxs, sctl}, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ext_maint();
    set_mode(1'b1, 1'b0, 1'b0);
    measure(0, 4 * txpath_pkg::REF_HALF_TICKS);
    $display("test external maintenance done");
  endtask : t_ext_maint

  task automatic t_sys_test();
    set_mode(1'b0, 1'b1, 1'b1);
    measure(1, 8 * txpath_pkg::REF_HALF_TICKS);
    $display("test system test done");
  endtask : t_sys_test

  task automatic t_user_hold();
    set_mode(1'b0, 1'b0, 1'b0);
    repeat (2 * txpath_pkg::REF_HALF_TICKS + 50)
    begin
      @(negedge clk);
      check({ext_clk, mon, mout}, 0);
    end
    $display("test user mode hold done");
  endtask : t_user_hold

  task automatic t_int_maint();
    int n;
    set_mode(1'b1, 1'b1, 1'b0);
    @(posedge clk);
    act   <= 1'b1;
    mdata <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({txf, mout, rxd, mon}, 4'h6);
    n = 0;
    repeat (4)
    begin
      @(posedge clk);
      step <= !step;
      repeat (10)
      begin
        @(negedge clk);
        n = n + (rxs ? 1 : 0);
      end
    end
    check(n, 2);
    @(posedge clk);
    mdata <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(mout, txf);
    @(posedge clk);
    act <= 1'b0;
    $display("test internal maintenance done");
  endtask : t_int_maint

  task automatic t_sync_follow();
    int k;
    set_mode(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    run <= 1'b1;
    for (k = 0; k < 5; k++)
    begin
      @(posedge clk);
      {abrt, flg, crc, som} <= 4'h8 >> k;
      repeat (100) @(posedge clk);
      @(negedge clk);
      check(sctl, 4'h8 >> k);
    end
    $display("test control sync done");
  endtask : t_sync_follow

  task automatic t_send(input logic p, input logic hold_load);
    int s, st;
    six_ones = 1'b0;
    @(posedge clk);
    run <= 1'b0;
    fill(8);
    @(posedge clk);
    proto <= p;
    skip  <= hold_load;
    som   <= 1'b1;
    act   <= 1'b1;
    run   <= 1'b1;
    repeat (60) @(posedge clk);
    som <= 1'b0;
    stream(600, s, st);
    check(rdy, !hold_load);
    @(posedge clk);
    run  <= 1'b0;
    skip <= 1'b0;
    // Let a last modem edge drain out of the synchroniser first
    repeat (4) @(posedge clk);
    stream(300, s, st);
    check(s, 0);
    @(posedge clk);
    run <= 1'b1;
    stream(2500, s, st);
    check(st != 0, !p);
    check(six_ones, p);
    check(rdy, 1'b1);
    @(posedge clk);
    flg       <= 1'b1;
    flag_seen = 1'b0;
    stream(600, s, st);
    check(flag_seen, 1'b1);
    @(posedge clk);
    flg <= 1'b0;
    act <= 1'b0;
    $display("test send protocol %0d done", p);
  endtask : t_send

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {clk, rstn, sel_lo, sel_hi, step, mdata, proto, abrt, flg, crc, som, skip, act, crc_msb, run, dv} = 0;
    data_in         = 8'h00;
    fails           = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_ext_maint();
    t_sys_test();
    t_user_hold();
    t_int_maint();
    t_sync_follow();
    @(posedge clk);
    {abrt, flg, crc, som} <= 4'h0;
    t_send(1'b0, 1'b1);
    t_send(1'b1, 1'b0);
    wrap_up();
  end

  initial
  begin
    repeat (95000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : sync_tx_path_maint_clock_tb
